// *** core_timing_pkg.sv ***
// Constants, lookup tables and carrier types for the instruction timing and
// memory map block. Assumes an APB master with 32-bit data and byte
// addresses, and a single 100 MHz clock shared with the fetch logic.
//
// Notes on behaviour
// - Every opcode decodes with its standard binary encoding and function.
// - Add, add-carry, subtract-borrow via bank register: 1 byte, 1 cycle.
// - Same ops direct, indirect or immediate: two cycles; indirect 1 byte.
// - Logic op into direct byte: 3 cycles; immediate source 3 bytes, 4.
// - Accumulator-only clear, complement, rotates, swap: 1 byte, 1 cycle.
// - Direct to bank register 4 cycles, to indirect RAM 5; two bytes.
// - Code byte reads via data pointer or program counter: one byte, three.
// - External data reads take 3 cycles, writes 4, either addressing.
// - Push direct takes four cycles, pop three; both two bytes.
// - Exchange with bank register 2 cycles; direct, indirect, nibble 3.
// - Indirect jump two cycles; short and absolute three; long jump four.
// - Bit-conditional jumps: 3 bytes, 4 cycles; set-then-clear clears.
// - Compare-jumps 3 bytes, 4; decrement-jump register 3, direct 4.
// - Carry set, clear, complement 1; bit into carry 2; write bit 3.
// - Top N 256-byte blocks of the 16 KB flash are reserved, N 0..16.
// - Internal RAM 00h-7Fh direct or indirect; banks, bit area, general.
// - RAM 80h-FFh only indirectly; direct goes to function registers.
// - External data 0000h-03FFh maps to on-chip 1 KB RAM when enabled.
// - Pointer access above 03FFh drives external strobes and address.
// - Page register gives upper byte for 8-bit indirect; resets 00h.
// - With RAM enabled, pages 0-3 internal; pages 4-255 go onto port 2.
// - With RAM disabled the page register is ignored; port 2 latch used.
// - Machine cycle is two clocks by default, one when timing select set.
// - RAM disable bit resets to 0 which enables the internal 1 KB RAM.
package core_timing_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_XRAM_PAGE  = 8'h86;
  localparam logic [7:0] IDX_IFACE_CTRL = 8'h8F;
  localparam logic [7:0] IDX_PORT2      = 8'hA0;
  localparam logic [7:0] IDX_ISP_BLOCKS = 8'h40;
  localparam logic [7:0] IDX_STATUS     = 8'h41;

  // Field positions and reset values.
  localparam int         CTRL_ONE_CLOCK_BIT   = 7;
  localparam int         CTRL_XRAM_DIS_BIT    = 1;
  localparam logic [7:0] XRAM_PAGE_RESET      = 8'h00;
  localparam logic [7:0] IFACE_CTRL_RESET     = 8'h00;
  localparam logic [7:0] PORT2_RESET          = 8'hFF;
  localparam logic [4:0] ISP_BLOCKS_RESET     = 5'h00;
  localparam logic [4:0] ISP_BLOCKS_MAX       = 5'h10;

  // Memory map boundaries.
  localparam logic [15:0] XRAM_LAST       = 16'h03FF;
  localparam logic [7:0]  XRAM_LAST_PAGE  = 8'h03;
  localparam logic [7:0]  BANK_LAST       = 8'h1F;
  localparam logic [7:0]  BIT_AREA_LAST   = 8'h2F;
  localparam logic [7:0]  LOWER_RAM_LAST  = 8'h7F;
  localparam logic [14:0] FLASH_SIZE      = 15'h4000;
  localparam int          XRAM_DEPTH      = 1024;

  // Clocks per machine cycle in each timing mode.
  localparam logic [3:0] CLOCKS_SLOW = 4'h2;
  localparam logic [3:0] CLOCKS_FAST = 4'h1;

  // Each entry is {bytes[1:0], machine cycles[2:0]}, indexed by opcode[7:4].
  localparam logic [4:0] TBL_REG [16] = '{
    5'h0A, 5'h0A, 5'h09, 5'h09, 5'h09, 5'h09, 5'h09, 5'h12,
    5'h13, 5'h09, 5'h14, 5'h1C, 5'h0A, 5'h13, 5'h09, 5'h0A};
  localparam logic [4:0] TBL_IND [16] = '{
    5'h0B, 5'h0B, 5'h0A, 5'h0A, 5'h0A, 5'h0A, 5'h0A, 5'h13,
    5'h14, 5'h0A, 5'h15, 5'h1C, 5'h0B, 5'h0B, 5'h0A, 5'h0B};
  localparam logic [4:0] TBL_DIR [16] = '{
    5'h13, 5'h13, 5'h12, 5'h12, 5'h12, 5'h12, 5'h12, 5'h1B,
    5'h1C, 5'h12, 5'h09, 5'h1C, 5'h13, 5'h1C, 5'h12, 5'h13};
  localparam logic [4:0] TBL_LOW4 [16] = '{
    5'h09, 5'h09, 5'h12, 5'h12, 5'h12, 5'h12, 5'h12, 5'h12,
    5'h0D, 5'h12, 5'h0D, 5'h1C, 5'h09, 5'h09, 5'h09, 5'h09};
  localparam logic [4:0] TBL_LOW3 [16] = '{
    5'h09, 5'h09, 5'h09, 5'h09, 5'h1C, 5'h1C, 5'h1C, 5'h0A,
    5'h0B, 5'h0B, 5'h09, 5'h09, 5'h09, 5'h09, 5'h0B, 5'h0C};
  localparam logic [4:0] TBL_LOW2 [16] = '{
    5'h1C, 5'h1E, 5'h0C, 5'h0C, 5'h13, 5'h13, 5'h13, 5'h12,
    5'h12, 5'h13, 5'h12, 5'h13, 5'h13, 5'h13, 5'h0B, 5'h0C};
  localparam logic [4:0] TBL_LOW0 [16] = '{
    5'h09, 5'h1C, 5'h1C, 5'h1C, 5'h13, 5'h13, 5'h13, 5'h13,
    5'h13, 5'h1B, 5'h12, 5'h12, 5'h14, 5'h13, 5'h0B, 5'h0C};
  localparam logic [4:0] ENT_ABS_JUMP = 5'h13;
  localparam logic [4:0] ENT_ABS_CALL = 5'h16;

  localparam logic [7:0] OP_XRD_PTR  = 8'hE0;
  localparam logic [7:0] OP_XWR_PTR  = 8'hF0;
  localparam logic [7:0] OP_CODE_PTR = 8'h93;
  localparam logic [7:0] OP_CODE_PC  = 8'h83;
  localparam logic [7:0] OP_JUMP_CLR = 8'h10;

  typedef enum logic [4:0] {
    MODE_REG   = 5'b00001,
    MODE_IND   = 5'b00010,
    MODE_DIR   = 5'b00100,
    MODE_IMM   = 5'b01000,
    MODE_OTHER = 5'b10000
  } mode_t;

  typedef enum logic [4:0] {
    REG_BANK    = 5'b00001,
    REG_BITS    = 5'b00010,
    REG_GENERAL = 5'b00100,
    REG_UPPER   = 5'b01000,
    REG_SFR     = 5'b10000
  } region_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } exec_state_t;

  typedef struct packed {
    logic [1:0] bytes;
    logic [2:0] cycles;
    mode_t      mode;
    logic       xdata_rd;
    logic       xdata_wr;
    logic       via_page;
    logic       code_read;
    logic       clear_on_branch;
  } decode_t;

endpackage

// *** core_timing.sv ***
// Instruction length and timing decoder with the data, external data and
// program memory map. Assumes the fetch logic presents one opcode at a time
// and holds operand addresses stable while the instruction runs.
`timescale 1ns/1ps

module core_timing
  import core_timing_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Instruction hand-off from fetch
  input  wire logic        instr_valid,
  input  wire logic [7:0]  instr_opcode,
  output logic             instr_ready,
  output decode_t          instr_info,
  output logic             instr_done,
  // External data operand
  input  wire logic [15:0] xdata_ptr,
  input  wire logic [7:0]  xdata_ri_addr,
  input  wire logic [7:0]  xdata_wdata,
  output logic      [7:0]  xdata_rdata,
  // Internal data RAM map
  input  wire logic [7:0]  data_addr,
  input  wire logic        data_indirect,
  output region_t          data_region,
  // Program memory map
  input  wire logic [13:0] code_addr,
  output logic             code_in_isp,
  // External memory bus
  output logic      [15:0] ext_addr,
  output logic             ext_rd_n,
  output logic             ext_wr_n,
  output logic      [7:0]  ext_dout,
  output logic             ext_dout_oe,
  input  wire logic [7:0]  ext_din,
  output logic      [7:0]  port2_out
);

  function automatic decode_t decode_op(input logic [7:0] op);
    decode_t    d;
    logic [4:0] e;
    d = '0;
    e = 5'h09;
    if (op[3]) begin
      e = TBL_REG[op[7:4]];
      d.mode = MODE_REG;
    end else begin
      d.mode = MODE_OTHER;
      case (op[2:0])
        3'd6, 3'd7: begin
          e = TBL_IND[op[7:4]];
          d.mode = MODE_IND;
        end
        3'd5: begin
          e = TBL_DIR[op[7:4]];
          d.mode = MODE_DIR;
        end
        3'd4: begin
          e = TBL_LOW4[op[7:4]];
          if (op[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                              4'h9, 4'hB})
            d.mode = MODE_IMM;
        end
        3'd3: e = TBL_LOW3[op[7:4]];
        3'd2: e = TBL_LOW2[op[7:4]];
        3'd1: e = op[4] ? ENT_ABS_CALL : ENT_ABS_JUMP;
        default: e = TBL_LOW0[op[7:4]];
      endcase
    end
    d.bytes  = e[4:3];
    d.cycles = e[2:0];
    d.xdata_rd = (op == OP_XRD_PTR) ||
                 ((op[7:1] == OP_XRD_PTR[7:1] + 7'h01));
    d.xdata_wr = (op == OP_XWR_PTR) ||
                 ((op[7:1] == OP_XWR_PTR[7:1] + 7'h01));
    d.via_page = (d.xdata_rd || d.xdata_wr) && op[1];
    d.code_read = (op == OP_CODE_PTR) || (op == OP_CODE_PC);
    d.clear_on_branch = (op == OP_JUMP_CLR);
    return d;
  endfunction

  // Software-visible state.
  logic [7:0]  xram_page_register;
  logic [7:0]  iface_ctrl;
  logic [7:0]  port2_latch;
  logic [4:0]  isp_blocks;

  logic        one_clock_mode;
  logic        xram_disable_bit;

  // Execution state.
  exec_state_t state;
  logic [3:0]  clocks_left;
  logic        ext_active;
  logic        int_active;
  logic [9:0]  int_index;
  logic [7:0]  xram [XRAM_DEPTH];

  // Three-stage input capture of the external data bus.
  logic [7:0]  din_s1;
  logic [7:0]  din_s2;
  logic [7:0]  din_s3;

  logic        apb_write;
  logic        apb_read;
  logic [7:0]  reg_index;
  logic        addr_mapped;

  decode_t     next_info;
  logic [3:0]  clocks_per_cycle;
  logic [3:0]  next_clocks;
  logic        accept;
  logic [15:0] eff_addr;
  logic        eff_internal;
  logic [15:0] isp_base;

  assign one_clock_mode   = iface_ctrl[CTRL_ONE_CLOCK_BIT];
  assign xram_disable_bit = iface_ctrl[CTRL_XRAM_DIS_BIT];

  // The slave never stalls, so every access finishes in its first
  // access-phase cycle.
  assign pready      = 1'b1;
  assign reg_index   = paddr[9:2];
  assign addr_mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                       (reg_index inside {IDX_XRAM_PAGE, IDX_IFACE_CTRL,
                                          IDX_PORT2, IDX_ISP_BLOCKS,
                                          IDX_STATUS});
  assign apb_write   = psel && penable && pwrite && addr_mapped;
  assign apb_read    = psel && penable && !pwrite;
  assign pslverr     = psel && penable && !addr_mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_read) begin
      case (reg_index)
        IDX_XRAM_PAGE:  prdata = {24'h00_0000, xram_page_register};
        IDX_IFACE_CTRL: prdata = {24'h00_0000, iface_ctrl};
        IDX_PORT2:      prdata = {24'h00_0000, port2_latch};
        IDX_ISP_BLOCKS: prdata = {27'h000_0000, isp_blocks};
        IDX_STATUS:     prdata = {24'h00_0000, clocks_left,
                                  1'b0, int_active, ext_active,
                                  state == ST_RUN};
        default:        prdata = 32'h0000_0000;
      endcase
    end
  end

  // The page register resets to page zero.
  always_ff @(posedge ref_clk) begin
    if (rst)
      xram_page_register <= XRAM_PAGE_RESET;
    else if (apb_write && reg_index == IDX_XRAM_PAGE)
      xram_page_register <= pwdata[7:0];
  end

  // Timing select and RAM disable both clear at reset.
  always_ff @(posedge ref_clk) begin
    if (rst)
      iface_ctrl <= IFACE_CTRL_RESET;
    else if (apb_write && reg_index == IDX_IFACE_CTRL)
      iface_ctrl <= pwdata[7:0];
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      port2_latch <= PORT2_RESET;
    else if (apb_write && reg_index == IDX_PORT2)
      port2_latch <= pwdata[7:0];
  end

  // Block counts above sixteen are clamped rather than wrapped, so a write
  // whose low byte exceeds sixteen reserves all sixteen blocks.
  always_ff @(posedge ref_clk) begin
    if (rst)
      isp_blocks <= ISP_BLOCKS_RESET;
    else if (apb_write && reg_index == IDX_ISP_BLOCKS)
      isp_blocks <= (pwdata[7:0] > 8'(ISP_BLOCKS_MAX)) ? ISP_BLOCKS_MAX
                                                        : pwdata[4:0];
  end

  // Opcode decode and clock budget.
  always_comb begin
    next_info = decode_op(instr_opcode);
    clocks_per_cycle = one_clock_mode ? CLOCKS_FAST : CLOCKS_SLOW;
    next_clocks = 4'(next_info.cycles * clocks_per_cycle);
  end

  assign instr_ready = (state == ST_IDLE);
  assign accept      = instr_valid && instr_ready;

  // Resolve where an external data access lands.
  always_comb begin
    eff_addr     = xdata_ptr;
    eff_internal = 1'b0;
    if (next_info.via_page) begin
      if (xram_disable_bit) begin
        eff_addr = {port2_latch, xdata_ri_addr};
      end else begin
        eff_addr = {xram_page_register, xdata_ri_addr};
        eff_internal = (xram_page_register <= XRAM_LAST_PAGE);
      end
    end else begin
      eff_internal = !xram_disable_bit && (xdata_ptr <= XRAM_LAST);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state       <= ST_IDLE;
      clocks_left <= 4'h0;
      instr_info  <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            state       <= ST_RUN;
            clocks_left <= next_clocks - 4'h1;
            instr_info  <= next_info;
          end
        end
        ST_RUN: begin
          if (clocks_left == 4'h0)
            state <= ST_IDLE;
          else
            clocks_left <= clocks_left - 4'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      instr_done <= 1'b0;
    else
      instr_done <= (state == ST_RUN) && (clocks_left == 4'h0);
  end

  // External strobes stay low for the whole instruction so that slow
  // memories see the widest window the timing mode allows.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_active  <= 1'b0;
      ext_addr    <= 16'h0000;
      ext_rd_n    <= 1'b1;
      ext_wr_n    <= 1'b1;
      ext_dout    <= 8'h00;
      ext_dout_oe <= 1'b0;
    end else if (accept && (next_info.xdata_rd || next_info.xdata_wr) &&
                 !eff_internal) begin
      ext_active  <= 1'b1;
      ext_addr    <= eff_addr;
      ext_rd_n    <= !next_info.xdata_rd;
      ext_wr_n    <= !next_info.xdata_wr;
      ext_dout    <= xdata_wdata;
      ext_dout_oe <= next_info.xdata_wr;
    end else if (state == ST_RUN && clocks_left == 4'h0) begin
      ext_active  <= 1'b0;
      ext_rd_n    <= 1'b1;
      ext_wr_n    <= 1'b1;
      ext_dout_oe <= 1'b0;
    end
  end

  // Port 2 shows the upper address byte only while an external access
  // runs, and the latch the rest of the time.
  always_ff @(posedge ref_clk) begin
    if (rst)
      port2_out <= PORT2_RESET;
    else if (accept && (next_info.xdata_rd || next_info.xdata_wr) &&
             !eff_internal)
      port2_out <= eff_addr[15:8];
    else if (!ext_active || (state == ST_RUN && clocks_left == 4'h0))
      port2_out <= port2_latch;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
      din_s3 <= 8'h00;
    end else begin
      din_s1 <= ext_din;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
    end
  end

  // Internal expanded RAM access.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_active <= 1'b0;
      int_index  <= 10'h000;
    end else if (accept && (next_info.xdata_rd || next_info.xdata_wr) &&
                 eff_internal) begin
      int_active <= 1'b1;
      int_index  <= eff_addr[9:0];
    end else if (state == ST_RUN && clocks_left == 4'h0) begin
      int_active <= 1'b0;
    end
  end

  generate
    for (genvar i = 0; i < XRAM_DEPTH; i++) begin : g_xram
      always_ff @(posedge ref_clk) begin
        if (rst)
          xram[i] <= 8'h00;
        else if (accept && next_info.xdata_wr && eff_internal &&
                 eff_addr[9:0] == 10'(i))
          xram[i] <= xdata_wdata;
      end
    end
  endgenerate

  // Read data lands at the last clock of the instruction. The external bus
  // value is only taken once the last two capture stages agree, so a bus
  // still settling keeps the previous byte.
  always_ff @(posedge ref_clk) begin
    if (rst)
      xdata_rdata <= 8'h00;
    else if (state == ST_RUN && clocks_left == 4'h0 &&
             instr_info.xdata_rd) begin
      if (int_active)
        xdata_rdata <= xram[int_index];
      else if (ext_active && din_s2 == din_s3)
        xdata_rdata <= din_s3;
    end
  end

  // Direct addresses above the lower half go to function registers;
  // only indirect access reaches the upper RAM.
  always_ff @(posedge ref_clk) begin
    if (rst)
      data_region <= REG_BANK;
    else if (data_addr <= BANK_LAST)
      data_region <= REG_BANK;
    else if (data_addr <= BIT_AREA_LAST)
      data_region <= REG_BITS;
    else if (data_addr <= LOWER_RAM_LAST)
      data_region <= REG_GENERAL;
    else if (data_indirect)
      data_region <= REG_UPPER;
    else
      data_region <= REG_SFR;
  end

  // The reserved service area grows downward from the top of flash in
  // 256-byte blocks; zero blocks reserve nothing.
  assign isp_base = 16'(FLASH_SIZE) - {3'b000, isp_blocks, 8'h00};

  always_ff @(posedge ref_clk) begin
    if (rst)
      code_in_isp <= 1'b0;
    else
      code_in_isp <= (isp_blocks != 5'h00) &&
                     ({2'b00, code_addr} >= isp_base);
  end

endmodule // core_timing

// *** core_timing_chk.sv ***
// Concurrent checks on the ports of the timing and memory map block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps

module core_timing_chk
  import core_timing_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Instruction hand-off
  input wire logic        instr_valid,
  input wire logic [7:0]  instr_opcode,
  input wire logic        instr_ready,
  input wire decode_t     instr_info,
  input wire logic        instr_done,
  // Internal data RAM map
  input wire logic [7:0]  data_addr,
  input wire logic        data_indirect,
  input wire region_t     data_region,
  // External memory bus
  input wire logic [15:0] ext_addr,
  input wire logic        ext_rd_n,
  input wire logic        ext_wr_n,
  input wire logic [7:0]  port2_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  reset_idle_a: assert property (
    $fell(rst) |-> instr_ready && ext_rd_n && ext_wr_n && port2_out == 8'hFF)
    else $error("outputs not idle after reset");
  strobe_excl_a: assert property (
    !(!ext_rd_n && !ext_wr_n)) else $error("both strobes low");
  page_drive_a: assert property (
    (!ext_rd_n || !ext_wr_n) |-> port2_out == ext_addr[15:8])
    else $error("port 2 differs from upper address");
  accept_busy_a: assert property (
    instr_valid && instr_ready |=> !instr_ready)
    else $error("ready stayed high after accept");
  busy_bound_a: assert property (
    $fell(instr_ready) |-> ##[1:12] instr_ready)
    else $error("instruction ran too long");
  done_ready_a: assert property (
    instr_done |-> instr_ready) else $error("done without ready");
  add_decode_a: assert property (
    instr_valid && instr_ready && instr_opcode[7:3] == 5'b00101 |=>
    instr_info.bytes == 2'd1 && instr_info.cycles == 3'd1)
    else $error("register add decoded wrongly");
  xwrite_decode_a: assert property (
    instr_valid && instr_ready && instr_opcode == 8'hF0 |=>
    instr_info.xdata_wr && instr_info.cycles == 3'd4)
    else $error("external write decoded wrongly");
  bit_jump_a: assert property (
    instr_valid && instr_ready && instr_opcode == 8'h10 |=>
    instr_info.clear_on_branch && instr_info.bytes == 2'd3)
    else $error("jump and clear decoded wrongly");
  sfr_direct_a: assert property (
    !data_indirect && data_addr[7] |=> data_region == REG_SFR)
    else $error("direct upper address not function register");
  upper_ind_a: assert property (
    data_indirect && data_addr[7] |=> data_region == REG_UPPER)
    else $error("indirect upper address not upper RAM");
endmodule // core_timing_chk

// *** xram_far.sv ***
// Behavioural external data RAM on the block's external bus.
// Assumes active-low strobes and a registered address from the block.
`timescale 1ns/1ps

module xram_far (
  // Clock
  input  wire logic        ref_clk,
  // Bus from the block
  input  wire logic [15:0] ext_addr,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  input  wire logic [7:0]  ext_dout,
  // Read data toward the block
  output logic      [7:0]  far_din
);
  logic [7:0]  mem [65536];
  logic [7:0]  idle_pat = 8'h00;
  logic [15:0] last_addr = 16'h0000;
  int          hits = 0;

  // Off a read the line toggles, so stale data can never pass for a match.
  assign far_din = !ext_rd_n ? mem[ext_addr] : idle_pat;

  always @(posedge ref_clk) begin
    idle_pat <= ~idle_pat;
    if (!ext_wr_n) mem[ext_addr] <= ext_dout;
    if (!ext_rd_n || !ext_wr_n) begin
      hits      <= hits + 1;
      last_addr <= ext_addr;
    end
  end
endmodule // xram_far

// *** core_timing_tb.sv ***
// Self-checking bench for the timing and memory map block.
// Assumes the package constants and an APB port with byte addresses.
`timescale 1ns/1ps

module core_timing_tb;
  import core_timing_pkg::*;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready;
  logic pslverr, instr_valid = 0, instr_ready, instr_done, e;
  logic data_indirect = 0, code_in_isp, ext_rd_n, ext_wr_n, ext_dout_oe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [7:0] instr_opcode = 8'h00, xdata_ri_addr = 8'h00, port2_out;
  logic [7:0] xdata_wdata = 8'h00, xdata_rdata, data_addr = 8'h00;
  logic [7:0] ext_dout, ext_din, far_din;
  logic [15:0] xdata_ptr = 16'h0000, ext_addr;
  logic [13:0] code_addr = 14'h0000;
  decode_t instr_info;
  region_t data_region;
  int errors = 0, num_checks = 0, n, h;
  logic [15:0] ops [32] = '{16'h2811, 16'h2612, 16'h2422, 16'h3811,
    16'h9811, 16'h9522, 16'h5334, 16'h5223, 16'hE411, 16'h3311, 16'hC411,
    16'hA824, 16'hA625, 16'h9313, 16'h8313, 16'hC024, 16'hD023, 16'hC812,
    16'hC523, 16'hD613, 16'h7312, 16'h8023, 16'h0234, 16'h0123, 16'h2034,
    16'h1034, 16'hB534, 16'hD823, 16'hD534, 16'hC311, 16'hB022, 16'h9223};
  logic [15:0] regions [8] = '{16'h1001, 16'h1F81, 16'h2502, 16'h2F02,
    16'h5084, 16'h7F04, 16'h9088, 16'h9010};
  logic [19:0] in_system_programming [6] = '{{5'd2, 14'h3DFF, 1'b0}, {5'd2, 14'h3E00, 1'b1},
    {5'd2, 14'h3FFF, 1'b1}, {5'd0, 14'h3FFF, 1'b0},
    {5'd16, 14'h3000, 1'b1}, {5'd16, 14'h2FFF, 1'b0}};

  always #5 ref_clk = ~ref_clk;
  // The data pin is shared, so the block reads its own value while driving.
  assign ext_din = ext_dout_oe ? ext_dout : far_din;

  core_timing dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .instr_ready(instr_ready), .instr_info(instr_info),
    .instr_done(instr_done), .xdata_ptr(xdata_ptr),
    .xdata_ri_addr(xdata_ri_addr), .xdata_wdata(xdata_wdata),
    .xdata_rdata(xdata_rdata), .data_addr(data_addr),
    .data_indirect(data_indirect), .data_region(data_region),
    .code_addr(code_addr), .code_in_isp(code_in_isp), .ext_addr(ext_addr),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_dout(ext_dout),
    .ext_dout_oe(ext_dout_oe), .ext_din(ext_din), .port2_out(port2_out));
  xram_far far (.ref_clk(ref_clk), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n), .ext_dout(ext_dout), .far_din(far_din));

  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic run(input logic [7:0] op, input logic [15:0] p,
                     input logic [7:0] ri, input logic [7:0] w);
    @(posedge ref_clk);
    instr_opcode  <= op;
    xdata_ptr     <= p;
    xdata_ri_addr <= ri;
    xdata_wdata   <= w;
    instr_valid   <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (instr_done !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic xop(input logic [7:0] op, input logic [15:0] p,
                     input logic [7:0] ri, input logic [7:0] w,
                     input logic hit, input logic [15:0] adr);
    h = far.hits;
    run(op, p, ri, w);
    check(32'(far.hits != h), 32'(hit));
    if (hit) check(32'(far.last_addr), 32'(adr));
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, ra(IDX_XRAM_PAGE), 32'h0000_0000);
    check(q, 32'h0000_0000);
    apb(1'b0, ra(IDX_IFACE_CTRL), 32'h0000_0000);
    check(q, 32'h0000_0000);
    apb(1'b0, ra(IDX_PORT2), 32'h0000_0000);
    check(q, 32'h0000_00FF);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check(32'(e), 32'h0000_0001);
    $display("register reset test done");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ra(IDX_IFACE_CTRL), {24'h00_0000, m[0], 7'h00});
      foreach (ops[i]) begin
        run(ops[i][15:8], 16'h0000, 8'h00, 8'h00);
        check(n, (2 - m) * ops[i][3:0]);
        check(32'(instr_info.cycles), 32'(ops[i][2:0]));
        check(32'(instr_info.bytes), 32'(ops[i][5:4]));
        check(32'(instr_info.code_read),
              32'(ops[i][15:8] inside {8'h93, 8'h83}));
      end
    end
    $display("instruction timing test done");
    apb(1'b1, ra(IDX_IFACE_CTRL), 32'h0000_0000);
    xop(8'hF0, 16'h1234, 8'h00, 8'h5A, 1'b1, 16'h1234);
    xop(8'hE0, 16'h1234, 8'h00, 8'h00, 1'b1, 16'h1234);
    check(32'(xdata_rdata), 32'h0000_005A);
    xop(8'hF0, 16'h0100, 8'h00, 8'hC3, 1'b0, 16'h0000);
    xop(8'hE0, 16'h0100, 8'h00, 8'h00, 1'b0, 16'h0000);
    check(32'(xdata_rdata), 32'h0000_00C3);
    apb(1'b1, ra(IDX_XRAM_PAGE), 32'h0000_0005);
    xop(8'hF2, 16'h0000, 8'h34, 8'hA5, 1'b1, 16'h0534);
    xop(8'hE3, 16'h0000, 8'h34, 8'h00, 1'b1, 16'h0534);
    check(32'(xdata_rdata), 32'h0000_00A5);
    apb(1'b1, ra(IDX_XRAM_PAGE), 32'h0000_0003);
    xop(8'hF3, 16'h0000, 8'h10, 8'h77, 1'b0, 16'h0000);
    apb(1'b1, ra(IDX_PORT2), 32'h0000_0007);
    apb(1'b1, ra(IDX_IFACE_CTRL), 32'h0000_0002);
    xop(8'hF2, 16'h0000, 8'h10, 8'h66, 1'b1, 16'h0710);
    $display("external data test done");
    foreach (regions[i]) begin
      @(posedge ref_clk);
      data_addr     <= regions[i][15:8];
      data_indirect <= regions[i][7];
      repeat (2) @(posedge ref_clk);
      #1;
      check(32'(data_region), 32'(regions[i][4:0]));
    end
    foreach (in_system_programming[i]) begin
      apb(1'b1, ra(IDX_ISP_BLOCKS), 32'(in_system_programming[i][19:15]));
      code_addr <= in_system_programming[i][14:1];
      repeat (2) @(posedge ref_clk);
      #1;
      check(32'(code_in_isp), 32'(in_system_programming[i][0]));
    end
    // Oversized block counts must clamp to the largest legal count.
    apb(1'b1, ra(IDX_ISP_BLOCKS), 32'h0000_001F);
    apb(1'b0, ra(IDX_ISP_BLOCKS), 32'h0000_0000);
    check(q, 32'(ISP_BLOCKS_MAX));
    apb(1'b0, ra(IDX_STATUS), 32'h0000_0000);
    check(q, 32'h0000_0000);
    $display("memory map test done");
    end_of_test();
  end
endmodule // core_timing_tb

bind core_timing core_timing_chk chk (.ref_clk(ref_clk), .rst(rst),
  .instr_valid(instr_valid), .instr_opcode(instr_opcode),
  .instr_ready(instr_ready), .instr_info(instr_info),
  .instr_done(instr_done), .data_addr(data_addr),
  .data_indirect(data_indirect), .data_region(data_region),
  .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
  .port2_out(port2_out));
